// File: rtl/occ_pkg.sv
// Package of offsets, field positions, reset values, timing and carrier types for the oscillator block
package occ_pkg;

    // ------------------------------------------------------------------
    // Register offsets (printed offsets are not all multiples of four: index * 4)
    // ------------------------------------------------------------------
    localparam logic [11:0] OCC_IDX_CLK_SRC = 12'h088e;
    localparam logic [11:0] OCC_IDX_READY = 12'h0890;
    localparam logic [11:0] OCC_IDX_FORCE = 12'h0891;
    localparam logic [11:0] OCC_IDX_TUNE = 12'h0892;
    localparam logic [11:0] OCC_IDX_FREQ = 12'h0893;
    localparam int OCC_ADDR_W = 14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OCC_SRC_LSB = 4;
    localparam int OCC_SRC_W = 2;
    localparam int OCC_BIT_HF = 6;
    localparam int OCC_BIT_MID = 5;
    localparam int OCC_BIT_LOW = 4;
    localparam int OCC_BIT_CONV = 2;
    localparam int OCC_BIT_FIX = 1;
    localparam int OCC_FREQ_W = 3;
    localparam int OCC_TRIM_W = 6;
    localparam int OCC_NUM_OSC = 5;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] OCC_READY_RST = 8'h00;
    localparam logic [7:0] OCC_FORCE_RST = 8'h00;
    localparam logic [7:0] OCC_FORCE_MASK = 8'h74;
    localparam logic [5:0] OCC_TRIM_RST = 6'h00;
    localparam logic [2:0] OCC_FREQ_RST = 3'h0;
    localparam logic [2:0] OCC_FREQ_MAX = 3'h5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int OCC_CLK_MHZ = 100;
    localparam int OCC_LOCK_US = 2;
    localparam int OCC_LOCK_CYC = OCC_LOCK_US * OCC_CLK_MHZ;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [OCC_ADDR_W-1:0] adr;
        logic [31:0] dat;
    } occ_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } occ_wb_rsp_t;

    typedef struct packed {
        logic hf;
        logic mid;
        logic low;
        logic conv;
        logic fix;
    } occ_osc_t;

endpackage

// File: rtl/occ_ready_tmr.sv
// Per-oscillator ready qualifier: runs, counts the settle time, then reports ready
`timescale 1ns/1ps
module occ_ready_tmr
    import occ_pkg::*;
#(
    parameter int SETTLE_CYC = OCC_LOCK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic osc_ok,
    // Status
    output logic ready
);

    localparam int CW = $clog2(SETTLE_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYC - 1);

    logic [CW-1:0] cnt_ff;
    logic ready_ff;
    logic [CW-1:0] nxt_cnt;
    logic nxt_ready;
    wire logic hold = !run || restart || !osc_ok;
    wire logic done = (cnt_ff == LAST);

    assign nxt_cnt = hold ? '0 : (done ? cnt_ff : cnt_ff + CW'(1));
    assign nxt_ready = !hold && (ready_ff || done);
    assign ready = ready_ff;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            ready_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            ready_ff <= nxt_ready;
        end
    end

endmodule

// File: rtl/occ_regs.sv
// Oscillator control and status registers on a classic Wishbone slave
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - Control register bits 5:4 read the reset-selected clock source, read only.
// RULE_02 - Status bit 6 shows high-frequency oscillator ready; zero when off or settling.
// RULE_03 - Status bit 5 shows medium-frequency oscillator ready; zero when off or settling.
// RULE_04 - Status bit 4 shows low-frequency oscillator ready; zero when off or settling.
// RULE_05 - Status bit 2 shows converter RC oscillator ready; zero when off or settling.
// RULE_06 - Status bit 1 shows fixed 1 MHz derived oscillator ready.
// RULE_07 - Enable bit 6 keeps high-frequency oscillator on; else only on request; the code also runs it while the medium or fixed 1 MHz oscillator runs.
// RULE_08 - Enable bit 5 forces medium-frequency oscillator on; else only on request.
// RULE_09 - Enable bit 4 forces low-frequency oscillator on; else only on request.
// RULE_10 - Enable bit 2 forces converter RC oscillator on; requests still start it.
// RULE_11 - Frequency codes 0 to 5 select 1 to 32 MHz; codes 6, 7 reserved.
// RULE_12 - Six-bit signed trim resets to zero, nominal frequency.
// RULE_13 - Ready and enable bits reset to zero; ready bits not writable.
// RULE_14 - Frequency write clears high ready, holds clock static until relock; the code does this only when the written code differs from the stored one.
// RULE_15 - Ready set only after the oscillator reaches its accuracy.
// RULE_16 - Converter RC oscillator starts when selected by converter or peripheral.
// RULE_17 - Unimplemented bits ignore writes and read zero.
// RULE_18 - Software should not write reserved frequency codes.
module occ_regs
    import occ_pkg::*;
#(
    parameter int SETTLE_CYC = OCC_LOCK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Wishbone slave
    input wire occ_wb_req_t wb_req,
    output occ_wb_rsp_t wb_rsp,
    // Reset configuration strap
    input wire logic [OCC_SRC_W-1:0] reset_clock_choice,
    // Oscillator side
    input wire occ_osc_t periph_req,
    input wire logic conv_rc_selected,
    input wire occ_osc_t osc_stable,
    output occ_osc_t osc_enable,
    output logic hf_clk_hold,
    output logic [OCC_FREQ_W-1:0] hf_freq_code,
    output logic [OCC_TRIM_W-1:0] hf_trim
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [OCC_NUM_OSC-1:0] req_s1_ff, req_s2_ff, stb_s1_ff, stb_s2_ff;
    logic conv_s1_ff, conv_s2_ff;
    logic [OCC_SRC_W-1:0] src_s1_ff, src_s2_ff;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            req_s1_ff <= '0;
            req_s2_ff <= '0;
            stb_s1_ff <= '0;
            stb_s2_ff <= '0;
            conv_s1_ff <= 1'b0;
            conv_s2_ff <= 1'b0;
            src_s1_ff <= '0;
            src_s2_ff <= '0;
        end else begin
            req_s1_ff <= periph_req;
            req_s2_ff <= req_s1_ff;
            stb_s1_ff <= osc_stable;
            stb_s2_ff <= stb_s1_ff;
            conv_s1_ff <= conv_rc_selected;
            conv_s2_ff <= conv_s1_ff;
            src_s1_ff <= reset_clock_choice;
            src_s2_ff <= src_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic ack_ff;
    logic [31:0] rdat_ff;
    wire logic bus_req = wb_req.cyc && wb_req.stb && !ack_ff;
    wire logic bus_wr = bus_req && wb_req.we && wb_req.sel[0];
    wire logic [11:0] word_idx = wb_req.adr[OCC_ADDR_W-1:2];
    wire logic hit_src = (word_idx == OCC_IDX_CLK_SRC);
    wire logic hit_rdy = (word_idx == OCC_IDX_READY);
    wire logic hit_force = (word_idx == OCC_IDX_FORCE);
    wire logic hit_tune = (word_idx == OCC_IDX_TUNE);
    wire logic hit_freq = (word_idx == OCC_IDX_FREQ);
    wire logic [7:0] wbyte = wb_req.dat[7:0];

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    logic [7:0] force_ff;
    logic [OCC_TRIM_W-1:0] trim_ff;
    logic [OCC_FREQ_W-1:0] freq_ff;
    logic [OCC_SRC_W-1:0] src_ff;
    logic src_cap_ff;
    logic [1:0] src_wait_ff;
    logic freq_chg_ff;

    // RULE_17 unused bits masked
    wire logic [7:0] nxt_force = (bus_wr && hit_force) ? (wbyte & OCC_FORCE_MASK) : force_ff;
    // RULE_12 signed trim store
    wire logic [OCC_TRIM_W-1:0] nxt_trim = (bus_wr && hit_tune) ? wbyte[OCC_TRIM_W-1:0] : trim_ff;
    // RULE_14 new code detected
    wire logic freq_new = bus_wr && hit_freq && (wbyte[OCC_FREQ_W-1:0] != freq_ff);
    // RULE_11 code stored as written
    wire logic [OCC_FREQ_W-1:0] nxt_freq = (bus_wr && hit_freq) ? wbyte[OCC_FREQ_W-1:0] : freq_ff;

    // RULE_13 enables reset to zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            force_ff <= OCC_FORCE_RST;
            trim_ff <= OCC_TRIM_RST;
            freq_ff <= OCC_FREQ_RST;
            freq_chg_ff <= 1'b0;
        end else begin
            force_ff <= nxt_force;
            trim_ff <= nxt_trim;
            freq_ff <= nxt_freq;
            freq_chg_ff <= freq_new;
        end
    end

    // RULE_01 strap captured once the synchroniser has filled
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            src_ff <= '0;
            src_cap_ff <= 1'b0;
            src_wait_ff <= '0;
        end else if (!src_cap_ff) begin
            src_ff <= src_s2_ff;
            src_cap_ff <= src_wait_ff[1];
            src_wait_ff <= src_wait_ff + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Oscillator run control
    // ------------------------------------------------------------------
    // RULE_07 high-frequency force or request
    wire logic run_hf = force_ff[OCC_BIT_HF] || req_s2_ff[4];
    // RULE_08 medium-frequency force or request
    wire logic run_mid = force_ff[OCC_BIT_MID] || req_s2_ff[3];
    // RULE_09 low-frequency force or request
    wire logic run_low = force_ff[OCC_BIT_LOW] || req_s2_ff[2];
    // RULE_10 RULE_16 converter RC auto start
    wire logic run_conv = force_ff[OCC_BIT_CONV] || req_s2_ff[1] || conv_s2_ff;
    // Fixed 1 MHz and medium outputs are derived from the high-frequency oscillator
    wire logic run_fix = req_s2_ff[0];
    wire logic [OCC_NUM_OSC-1:0] run_vec = {run_hf || run_mid || run_fix, run_mid, run_low,
                                            run_conv, run_fix};
    wire logic [OCC_NUM_OSC-1:0] restart_vec = {freq_chg_ff, 4'h0};

    // ------------------------------------------------------------------
    // Ready qualification
    // ------------------------------------------------------------------
    logic [OCC_NUM_OSC-1:0] rdy_raw;
    logic [OCC_NUM_OSC-1:0] en_ff;
    logic [OCC_NUM_OSC-1:0] rdy_ff;
    logic hold_ff;

    // RULE_15 ready after settle time
    genvar gi;
    generate
        for (gi = 0; gi < OCC_NUM_OSC; gi++) begin : g_osc
            occ_ready_tmr #(
                .SETTLE_CYC(SETTLE_CYC)
            ) u_tmr (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .run(run_vec[gi]),
                .restart(restart_vec[gi] || freq_new && (gi == OCC_NUM_OSC - 1)),
                .osc_ok(stb_s2_ff[gi]),
                .ready(rdy_raw[gi])
            );
        end
    endgenerate

    // Derived outputs need their parent oscillator ready as well
    wire logic [OCC_NUM_OSC-1:0] nxt_rdy = {rdy_raw[4], rdy_raw[3] && rdy_raw[4], rdy_raw[2],
                                            rdy_raw[1], rdy_raw[0] && rdy_raw[4]};

    // RULE_14 clock held static during relock
    wire logic nxt_hold = run_vec[4] && !rdy_raw[4] && (freq_new || hold_ff || freq_chg_ff);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            en_ff <= '0;
            rdy_ff <= '0;
            hold_ff <= 1'b0;
        end else begin
            en_ff <= run_vec;
            rdy_ff <= nxt_rdy & ~{freq_new, 4'h0};
            hold_ff <= nxt_hold;
        end
    end

    assign osc_enable = en_ff;
    assign hf_clk_hold = hold_ff;
    assign hf_freq_code = freq_ff;
    assign hf_trim = trim_ff;

    // ------------------------------------------------------------------
    // Read mux and acknowledge
    // ------------------------------------------------------------------
    // RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 status layout
    wire logic [7:0] rdy_byte = {1'b0, rdy_ff[4], rdy_ff[3], rdy_ff[2], 1'b0, rdy_ff[1],
                                 rdy_ff[0], 1'b0};
    wire logic [7:0] src_byte = {2'b00, src_ff, 4'h0};
    // RULE_17 unmapped reads zero
    wire logic [7:0] rd_byte = hit_src ? src_byte :
                               hit_rdy ? rdy_byte :
                               hit_force ? force_ff :
                               hit_tune ? {2'b00, trim_ff} :
                               hit_freq ? {5'h00, freq_ff} : 8'h00;
    wire logic [31:0] nxt_rdat = bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff <= 1'b0;
            rdat_ff <= '0;
        end else begin
            ack_ff <= bus_req;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_rsp.ack = ack_ff;
    assign wb_rsp.dat = rdat_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_SRC_RO: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_01
        src_cap_ff && $past(src_cap_ff) |-> $stable(src_ff))
        else $error("clock source indicator changed");

    AST_HF_RDY_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_02
        !en_ff[4] |-> ##1 !rdy_ff[4])
        else $error("hf ready while not running");

    AST_MID_RDY: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
        rdy_ff[3] |-> rdy_ff[4] || $past(freq_new))
        else $error("mid ready without parent");

    AST_LOW_RDY_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_04
        !en_ff[2] |-> ##1 !rdy_ff[2])
        else $error("low ready while not running");

    AST_CONV_AUTO: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_16
        conv_s2_ff |=> en_ff[1])
        else $error("converter oscillator not started");

    AST_HF_FORCE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_07
        force_ff[OCC_BIT_HF] |=> en_ff[4])
        else $error("hf force not applied");

    AST_LOW_FORCE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_09
        force_ff[OCC_BIT_LOW] |=> en_ff[2])
        else $error("low force not applied");

    AST_FREQ_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_14
        freq_new |=> !rdy_ff[4] ##1 !rdy_ff[4])
        else $error("hf ready not cleared on frequency change");

    AST_MASK: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_17
        (force_ff & ~OCC_FORCE_MASK) == 8'h00)
        else $error("unimplemented enable bit set");

    AST_ACK_ONE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ack_ff |=> !ack_ff)
        else $error("ack held two cycles");

    AST_ACK_TURN: assert property (@(posedge clk_sys) disable iff (!arst_n)
        bus_req |=> ack_ff)
        else $error("request not acknowledged next cycle");

    AST_RSP_IDLE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_17
        !ack_ff |-> (wb_rsp.dat == 32'h0000_0000))
        else $error("read data not zero outside ack");

    AST_RSP_UPPER: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_17
        wb_rsp.dat[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");

    AST_MID_FORCE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
        force_ff[OCC_BIT_MID] |=> en_ff[3] && en_ff[4])
        else $error("mid force not applied");

    AST_CONV_FORCE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_10
        force_ff[OCC_BIT_CONV] |=> en_ff[1])
        else $error("converter force not applied");

    AST_LOW_REQ: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_09
        req_s2_ff[2] |=> en_ff[2])
        else $error("low request not applied");

    AST_MID_RDY_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
        !en_ff[3] |-> ##1 !rdy_ff[3])
        else $error("mid ready while not running");

    AST_CONV_RDY_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_05
        !en_ff[1] |-> ##1 !rdy_ff[1])
        else $error("converter ready while not running");

    AST_FIX_RDY_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
        !en_ff[0] |-> ##1 !rdy_ff[0])
        else $error("fixed ready while not running");

    AST_FIX_RDY: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
        rdy_ff[0] |-> rdy_ff[4] || $past(freq_new))
        else $error("fixed ready without parent");

    AST_HF_SETTLED: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_15
        rdy_ff[4] |-> $past(stb_s2_ff[4], 2))
        else $error("hf ready without stable oscillator");

    AST_LOW_SETTLED: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_15
        rdy_ff[2] |-> $past(stb_s2_ff[2], 2))
        else $error("low ready without stable oscillator");

    AST_FREQ_STORE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_11
        bus_wr && hit_freq |=> (freq_ff == OCC_FREQ_W'($past(wbyte))))
        else $error("frequency code not stored");

    AST_FREQ_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_11
        !(bus_wr && hit_freq) |=> $stable(freq_ff))
        else $error("frequency code changed without write");

    AST_TRIM_STORE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_12
        bus_wr && hit_tune |=> (trim_ff == OCC_TRIM_W'($past(wbyte))))
        else $error("trim not stored");

    AST_HOLD_RISE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_14
        freq_new && force_ff[OCC_BIT_HF] |-> ##2 hf_clk_hold)
        else $error("hf clock not held on frequency change");

    AST_HOLD_NOT_RDY: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_14
        hold_ff |-> !rdy_ff[4])
        else $error("hf ready while clock held");

endmodule

// File: dv/occ_osc_model.sv
// Behavioural oscillator set that settles some cycles after its enable rises
`timescale 1ns/1ps
module occ_osc_model
    import occ_pkg::*;
#(
    parameter int FAST_CYC = 2,
    parameter int SLOW_CYC = 6
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Oscillator side
    input wire occ_osc_t osc_enable,
    output occ_osc_t osc_stable
);
    logic [OCC_NUM_OSC-1:0] en_v;
    logic [OCC_NUM_OSC-1:0] stable_ff;
    int cnt_ff [OCC_NUM_OSC];
    assign en_v = osc_enable;
    assign osc_stable = stable_ff;
    // A stopped oscillator loses stability at once; hf is quick, the rest slow
    always @(posedge clk_sys or negedge arst_n) begin
        for (int i = 0; i < OCC_NUM_OSC; i++) begin
            if (!arst_n || !en_v[i]) begin
                cnt_ff[i] <= 0;
                stable_ff[i] <= 1'b0;
            end else if (cnt_ff[i] < ((i == 4) ? FAST_CYC : SLOW_CYC)) begin
                cnt_ff[i] <= cnt_ff[i] + 1;
            end else begin
                stable_ff[i] <= 1'b1;
            end
        end
    end
endmodule

// File: dv/osc_control_status_regs_tb.sv
// Self-checking bench for the oscillator control and status registers
`timescale 1ns/1ps
module osc_control_status_regs_tb
    import occ_pkg::*;
;
    localparam logic [1:0] STRAP = 2'b10;
    localparam logic [13:0] A_SRC = {OCC_IDX_CLK_SRC, 2'b00};
    localparam logic [13:0] A_RDY = {OCC_IDX_READY, 2'b00};
    localparam logic [13:0] A_FRC = {OCC_IDX_FORCE, 2'b00};
    localparam logic [13:0] A_TRM = {OCC_IDX_TUNE, 2'b00};
    localparam logic [13:0] A_FRQ = {OCC_IDX_FREQ, 2'b00};
    localparam logic [13:0] A_GAP = 14'h223C;
    localparam logic [7:0] FBIT [4] = '{8'h40, 8'h20, 8'h10, 8'h04};
    localparam logic [7:0] FRDY [4] = '{8'h40, 8'h60, 8'h10, 8'h04};
    localparam logic [4:0] FEN [4] = '{5'h10, 5'h18, 5'h04, 5'h02};
    localparam logic [4:0] RQ [6] = '{5'h01, 5'h04, 5'h08, 5'h10, 5'h00, 5'h02};
    localparam logic [7:0] RRDY [6] = '{8'h42, 8'h10, 8'h60, 8'h40, 8'h04, 8'h04};
    localparam logic [4:0] REN [6] = '{5'h11, 5'h04, 5'h18, 5'h10, 5'h02, 5'h02};
    localparam logic [7:0] TW [3] = '{8'h1f, 8'he0, 8'h00};
    localparam logic [7:0] TR [3] = '{8'h1f, 8'h20, 8'h00};
    logic clk_sys;
    logic arst_n;
    occ_wb_req_t wb_req;
    occ_wb_rsp_t wb_rsp;
    occ_osc_t periph_req;
    logic conv_rc_selected;
    occ_osc_t osc_stable;
    occ_osc_t osc_enable;
    logic hf_clk_hold;
    logic [OCC_FREQ_W-1:0] hf_freq_code;
    logic [OCC_TRIM_W-1:0] hf_trim;
    logic [2:0] code;
    int errors = 0;
    int n_checks = 0;
    int cyc_cnt = 0;

    occ_regs #(.SETTLE_CYC(8)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .reset_clock_choice(STRAP), .periph_req(periph_req),
        .conv_rc_selected(conv_rc_selected), .osc_stable(osc_stable),
        .osc_enable(osc_enable), .hf_clk_hold(hf_clk_hold), .hf_freq_code(hf_freq_code),
        .hf_trim(hf_trim));
    occ_osc_model osc_model_u (.clk_sys(clk_sys), .arst_n(arst_n), .osc_enable(osc_enable),
        .osc_stable(osc_stable));

    always #5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic cycle: hold the request until ack is sampled, then release
    task automatic wb_xfer(input logic [13:0] a, input logic wr, input logic [7:0] d,
                           output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr, sel: 4'h1, adr: a, dat: {24'h0, d}};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        q = wb_rsp.dat;
        chk("ack", {31'h0, wb_rsp.ack}, 32'h1);
        wb_req <= '0;
    endtask

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb_xfer(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [13:0] a, input logic [7:0] exp);
        logic [31:0] q;
        wb_xfer(a, 1'b0, 8'h00, q);
        chk(what, q, {24'h0, exp});
    endtask

    task automatic poll(input string what, input logic [13:0] a, input logic [7:0] exp);
        logic [31:0] q;
        int k;
        k = 0;
        do begin
            wb_xfer(a, 1'b0, 8'h00, q);
            k++;
        end while (q !== {24'h0, exp} && k < 60);
        chk(what, q, {24'h0, exp});
    endtask

    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        wb_req = '0;
        periph_req = '0;
        conv_rc_selected = 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk("src", A_SRC, {2'b00, STRAP, 4'h0});
        rd_chk("ready", A_RDY, 8'h00);
        rd_chk("force", A_FRC, 8'h00);
        rd_chk("trim", A_TRM, 8'h00);
        wr(A_SRC, 8'hff);
        rd_chk("src_ro", A_SRC, {2'b00, STRAP, 4'h0});
        wr(A_RDY, 8'hff);
        rd_chk("ready_ro", A_RDY, 8'h00);
        wr(A_FRC, 8'hff);
        rd_chk("force_mask", A_FRC, 8'h74);
        wr(A_FRC, 8'h00);
        rd_chk("gap", A_GAP, 8'h00);
        poll("ready_clear", A_RDY, 8'h00);
        $display("test reset_access done");
        for (int i = 0; i < 4; i++) begin
            wr(A_FRC, FBIT[i]);
            rd_chk("force_rb", A_FRC, FBIT[i]);
            poll("ready_forced", A_RDY, FRDY[i]);
            chk("enable_forced", {27'h0, osc_enable}, {27'h0, FEN[i]});
            wr(A_FRC, 8'h00);
            poll("ready_off", A_RDY, 8'h00);
            chk("enable_off", {27'h0, osc_enable}, 32'h0);
        end
        $display("test force_enable done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            periph_req <= RQ[i];
            conv_rc_selected <= (i == 4);
            poll("ready_req", A_RDY, RRDY[i]);
            chk("enable_req", {27'h0, osc_enable}, {27'h0, REN[i]});
            @(posedge clk_sys);
            periph_req <= '0;
            conv_rc_selected <= 1'b0;
            poll("ready_idle", A_RDY, 8'h00);
        end
        $display("test periph_request done");
        wr(A_FRC, 8'h40);
        poll("hf_up", A_RDY, 8'h40);
        for (int c = 1; c <= 6; c++) begin
            code = 3'(c % 6);
            wr(A_FRQ, {5'h1f, code});
            @(negedge clk_sys);
            chk("hold_on", {31'h0, hf_clk_hold}, 32'h1);
            chk("code_out", {29'h0, hf_freq_code}, {29'h0, code});
            rd_chk("hf_lost", A_RDY, 8'h00);
            poll("hf_back", A_RDY, 8'h40);
            @(negedge clk_sys);
            chk("hold_off", {31'h0, hf_clk_hold}, 32'h0);
            rd_chk("freq_rb", A_FRQ, {5'h00, code});
        end
        wr(A_FRQ, 8'h00);
        @(negedge clk_sys);
        chk("hold_same", {31'h0, hf_clk_hold}, 32'h0);
        rd_chk("hf_kept", A_RDY, 8'h40);
        $display("test freq_select done");
        for (int i = 0; i < 3; i++) begin
            wr(A_TRM, TW[i]);
            rd_chk("trim_rb", A_TRM, TR[i]);
            chk("trim_out", {26'h0, hf_trim}, {24'h0, TR[i]});
        end
        $display("test trim done");
        wr(A_TRM, 8'h1f);
        wr(A_FRQ, 8'h03);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk("src_again", A_SRC, {2'b00, STRAP, 4'h0});
        rd_chk("force_rst", A_FRC, 8'h00);
        rd_chk("ready_rst", A_RDY, 8'h00);
        rd_chk("trim_rst", A_TRM, 8'h00);
        rd_chk("freq_rst", A_FRQ, 8'h00);
        chk("hold_rst", {31'h0, hf_clk_hold}, 32'h0);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule
